/* rtl/tdc_pkg.sv */
// shared constants, types and states of the hit capture block
package tdc_pkg;
  // channel and group geometry
  localparam int NUM_CH   = 64;
  localparam int SYS_CH   = 192;
  localparam int GRP_SIZE = 16;
  localparam int NUM_GRP  = NUM_CH / GRP_SIZE;
  localparam int GRP_W    = 4;
  localparam int CH_W     = 8;
  // fine sampler: eight samples per word, three fine bits
  localparam int FINE_N   = 8;
  localparam int FINE_W   = 3;
  // sampling rates in MHz, baseline and fast option
  localparam int SAMPLE_MHZ      = 1000;
  localparam int SAMPLE_CLK_MHZ  = 500;
  localparam int FAST_SAMPLE_MHZ = 1250;
  localparam int FAST_CLK_MHZ    = 625;
  // time stamp layout
  localparam int COARSE_NS = 8;
  localparam int COARSE_W  = 13;
  localparam int TIME_W    = COARSE_W + FINE_W;
  // group hit memory
  localparam int MEM_DEPTH = 1024;
  localparam int ADDR_W    = 10;
  localparam int FILL_W    = 11;
  // retention span and its count of ref_clk cycles
  localparam int REF_PERIOD_NS = 10;
  localparam int HOLD_NS       = 8000;
  localparam int HOLD_CYCLES   = HOLD_NS / REF_PERIOD_NS;
  // output word tags
  localparam logic [3:0] TYPE_HIT  = 4'h8;
  localparam logic [3:0] TYPE_FILL = 4'hf;

  // one queued hit
  typedef struct packed {
    logic              trail;
    logic [CH_W-1:0]   chan;
    logic [TIME_W-1:0] stamp;
  } tdc_hit_s;

  // readout sequencer states
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_ADDR  = 3'b001,
    S_CHECK = 3'b010,
    S_SEND  = 3'b011,
    S_END   = 3'b100
  } tdc_state_e;
endpackage

/* rtl/tdc_hit_mem.sv */
// group hit memory, one write port, registered read port
`timescale 1ns/1ns
module tdc_hit_mem
#(
  parameter int W  = 25,
  parameter int AW = 10
)
(
  // clock and enable
  input  wire logic          clk,
  input  wire logic          ce,
  // write side
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // read side
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);
  logic [W-1:0] store [2**AW];

  // write and registered read
  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      if (we)
        store[waddr] <= wdata;
      rdata <= store[raddr];
    end
  end
endmodule // tdc_hit_mem

/* rtl/tdc_hit_capture.sv */
// tdc hit capture: edge finding, channel queues, group memories, readout
`timescale 1ns/1ns
module tdc_hit_capture
(
  // clock, reset and enable
  input  wire logic                                          ref_clk,
  input  wire logic                                          rst_n,
  input  wire logic                                          ce,
  // sampler words, bit 0 earliest
  input  wire logic [tdc_pkg::NUM_CH-1:0][tdc_pkg::FINE_N-1:0] fineWords,
  // configuration
  input  wire logic [1:0]                                    instIdx,
  input  wire logic [tdc_pkg::TIME_W-1:0]                    winOffset,
  input  wire logic [tdc_pkg::TIME_W-1:0]                    winWidth,
  // trigger and event builder bus
  input  wire logic                                          trigger,
  input  wire logic                                          evReady,
  output logic      [31:0]                                   evData,
  output logic                                               evValid,
  output logic                                               evLast,
  output logic                                               busy
);
  ////////////////////////////////////////////////////////////////////////////
  logic [tdc_pkg::COARSE_W-1:0] coarse;
  logic [tdc_pkg::NUM_CH-1:0]   prevBit;
  logic [tdc_pkg::NUM_CH-1:0]   pend;
  logic [tdc_pkg::NUM_CH-1:0]   found;
  wire  [tdc_pkg::NUM_CH-1:0]   grantVec;
  tdc_pkg::tdc_hit_s            qEntry   [tdc_pkg::NUM_CH];
  tdc_pkg::tdc_hit_s            newEntry [tdc_pkg::NUM_CH];
  logic [4:0]                   pick     [tdc_pkg::NUM_GRP];
  logic [tdc_pkg::ADDR_W-1:0]   wrPtr    [tdc_pkg::NUM_GRP];
  logic [tdc_pkg::FILL_W-1:0]   fill     [tdc_pkg::NUM_GRP];
  logic [tdc_pkg::GRP_W-1:0]    rrLast   [tdc_pkg::NUM_GRP];
  logic [tdc_pkg::ADDR_W-1:0]   baseAddr [tdc_pkg::NUM_GRP];
  tdc_pkg::tdc_hit_s            rdWord   [tdc_pkg::NUM_GRP];
  tdc_pkg::tdc_state_e          state;
  logic [1:0]                   grp;
  logic [tdc_pkg::ADDR_W-1:0]   rdAddr;
  logic [tdc_pkg::FILL_W-1:0]   left;
  logic [tdc_pkg::TIME_W-1:0]   winStart;

  // first transition in {word, previous last sample}
  function automatic logic [3:0] firstEdge(input logic [8:0] s);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 7; i >= 0; i--)
      if (s[i+1] != s[i])
        r = {1'b1, 3'(i)};
    return r;
  endfunction

  // nearest request after the last granted one
  function automatic logic [4:0] rrPick(input logic [15:0] req, input logic [3:0] last);
    logic [3:0] j;
    logic [4:0] r;
    r = 5'h0;
    for (int k = 16; k >= 1; k--)
    begin
      j = last + 4'(k);
      if (req[j])
        r = {1'b1, j};
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // 64 channels, one sampler word each per cycle
  for (genvar c = 0; c < tdc_pkg::NUM_CH; c++)
  begin : g_ch
    wire [8:0] seq = {fineWords[c], prevBit[c]};
    wire [3:0] fe  = firstEdge(seq);
    assign found[c] = fe[3];
    // flag is level before the transition
    assign newEntry[c] = '{trail: seq[fe[2:0]], chan: {instIdx, 6'(c)},
                           stamp: {coarse, fe[2:0]}};
  end

  for (genvar g = 0; g < tdc_pkg::NUM_GRP; g++)
  begin : g_grp
    assign pick[g] = rrPick(pend[g*tdc_pkg::GRP_SIZE +: tdc_pkg::GRP_SIZE], rrLast[g]);
    assign grantVec[g*tdc_pkg::GRP_SIZE +: tdc_pkg::GRP_SIZE] =
      pick[g][4] ? (16'h1 << pick[g][3:0]) : 16'h0;
    assign baseAddr[g] = wrPtr[g] - fill[g][tdc_pkg::ADDR_W-1:0];
    tdc_hit_mem #(.W($bits(tdc_pkg::tdc_hit_s)), .AW(tdc_pkg::ADDR_W)) u_mem
    (
      .clk   (ref_clk),
      .ce    (ce),
      .we    (pick[g][4]),
      .waddr (wrPtr[g]),
      .wdata (qEntry[g*tdc_pkg::GRP_SIZE + int'(pick[g][3:0])]),
      .raddr (rdAddr),
      .rdata (rdWord[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // coarse counter cleared by common reset
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      coarse <= '0;
    else if (ce)
      coarse <= coarse + 13'h1;
  end

  // one queue entry per channel, new edge wins over grant clear
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prevBit <= '0;
      pend    <= '0;
      for (int c = 0; c < tdc_pkg::NUM_CH; c++)
        qEntry[c] <= '0;
    end
    else if (ce)
    begin
      for (int c = 0; c < tdc_pkg::NUM_CH; c++)
      begin
        prevBit[c] <= fineWords[c][tdc_pkg::FINE_N-1];
        if (found[c] && (!pend[c] || grantVec[c]))
        begin
          pend[c]   <= 1'b1;
          qEntry[c] <= newEntry[c];
        end
        else if (grantVec[c])
          pend[c] <= 1'b0;
      end
    end
  end

  // circular memory, oldest overwritten only after 1024 hits
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int g = 0; g < tdc_pkg::NUM_GRP; g++)
      begin
        wrPtr[g]  <= '0;
        fill[g]   <= '0;
        rrLast[g] <= 4'hf;
      end
    end
    else if (ce)
    begin
      for (int g = 0; g < tdc_pkg::NUM_GRP; g++)
        if (pick[g][4])
        begin
          wrPtr[g]  <= wrPtr[g] + 10'h1;
          rrLast[g] <= pick[g][3:0];
          if (fill[g] != 11'(tdc_pkg::MEM_DEPTH))
            fill[g] <= fill[g] + 11'h1;
        end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // readout selection, window from bus settings
  wire tdc_pkg::tdc_hit_s     rdHit     = rdWord[grp];
  wire [tdc_pkg::TIME_W-1:0]  trigStart = {coarse, 3'h0} - winOffset;
  wire [tdc_pkg::TIME_W-1:0]  rel       = rdHit.stamp - winStart;
  wire                        inWin     = rel < winWidth;
  wire [1:0]                  nextGrp   = grp + 2'h1;
  wire [31:0] hitWord  = {1'b1, tdc_pkg::TYPE_HIT, rdHit.trail, 2'b00, rdHit.chan, rel};
  wire [31:0] fillWord = {1'b1, tdc_pkg::TYPE_FILL, 27'h0};

  // fragment sequencer, walks each group oldest to newest
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state    <= tdc_pkg::S_IDLE;
      grp      <= '0;
      rdAddr   <= '0;
      left     <= '0;
      winStart <= '0;
      busy     <= 1'b0;
      evData   <= '0;
      evValid  <= 1'b0;
      evLast   <= 1'b0;
    end
    else if (ce)
    begin
      case (state)
        tdc_pkg::S_IDLE:
          if (trigger)
          begin
            state    <= tdc_pkg::S_ADDR;
            busy     <= 1'b1;
            grp      <= 2'h0;
            rdAddr   <= baseAddr[0];
            left     <= fill[0];
            winStart <= trigStart;
          end
        tdc_pkg::S_ADDR:
          if (left == '0)
          begin
            if (grp == 2'(tdc_pkg::NUM_GRP - 1))
            begin
              state   <= tdc_pkg::S_END;
              evData  <= fillWord;
              evValid <= 1'b1;
              evLast  <= 1'b1;
            end
            else
            begin
              grp    <= nextGrp;
              rdAddr <= baseAddr[nextGrp];
              left   <= fill[nextGrp];
            end
          end
          else
            state <= tdc_pkg::S_CHECK;
        tdc_pkg::S_CHECK:
          if (inWin)
          begin
            state   <= tdc_pkg::S_SEND;
            evData  <= hitWord;
            evValid <= 1'b1;
          end
          else
          begin
            state  <= tdc_pkg::S_ADDR;
            rdAddr <= rdAddr + 10'h1;
            left   <= left - 11'h1;
          end
        tdc_pkg::S_SEND:
          if (evReady)
          begin
            state   <= tdc_pkg::S_ADDR;
            evValid <= 1'b0;
            rdAddr  <= rdAddr + 10'h1;
            left    <= left - 11'h1;
          end
        tdc_pkg::S_END:
          if (evReady)
          begin
            state   <= tdc_pkg::S_IDLE;
            evValid <= 1'b0;
            evLast  <= 1'b0;
            busy    <= 1'b0;
          end
        default:
          state <= tdc_pkg::S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_coarse_step: assert property (ce |=> coarse == 13'($past(coarse) + 13'h1))
    else $error("coarse counter did not step");
  a_edge_queued: assert property (ce && found[0] && !pend[0] |=> pend[0])
    else $error("edge not queued");
  a_rise_flag: assert property (ce && found[0] && !pend[0] && !prevBit[0]
    |=> !qEntry[0].trail)
    else $error("rising edge flagged as trailing");
  a_rr_bound: assert property (pend[0] |-> ##[0:16] (grantVec[0] || !ce))
    else $error("channel queue starved");
  a_fill_cap: assert property (fill[0] <= 11'(tdc_pkg::MEM_DEPTH))
    else $error("group fill above depth");
  a_word_tag: assert property (evValid |-> evData[31])
    else $error("word without defining bit");
  a_hit_chan: assert property (evValid && !evLast |-> evData[30:27] == tdc_pkg::TYPE_HIT
    && evData[23:16] < 8'(tdc_pkg::SYS_CH))
    else $error("bad hit tag or channel");
  a_win_time: assert property (evValid && !evLast |-> evData[15:0] < winWidth)
    else $error("hit outside window");
  a_data_hold: assert property (evValid && !evReady |=> evValid && $stable(evData))
    else $error("word dropped before accept");
  a_trig_busy: assert property (ce && trigger && !busy |=> busy)
    else $error("trigger not taken");

  c_trigger: cover property (ce && trigger && !busy);
  c_hit_sent: cover property (evValid && evReady && !evLast);
  c_frag_end: cover property (evValid && evReady && evLast);
  c_grant: cover property (ce && grantVec[0]);
endmodule // tdc_hit_capture

/* testbench/tdc_ev_builder.sv */
// event builder model: takes fragment words, stalls on request
`timescale 1ns/1ns
module tdc_ev_builder
(
  // clock and enable
  input  wire logic        ref_clk,
  input  wire logic        ce,
  // event bus
  input  wire logic [31:0] evData,
  input  wire logic        evValid,
  input  wire logic        evLast,
  output logic             evReady,
  // stall control
  input  wire logic        stallEn
);
  logic [31:0] words[$];
  int          fragCount;
  logic [7:0]  lfsr;

  initial
  begin
    evReady   = 1'b0;
    fragCount = 0;
    lfsr      = 8'h5a;
  end

  // ready moves only off the sampling edge
  always @(negedge ref_clk)
  begin
    lfsr    = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    evReady = !stallEn || lfsr[0];
  end

  always @(posedge ref_clk)
    if (evValid === 1'b1 && evReady && ce === 1'b1)
    begin
      words.push_back(evData);
      if (evLast === 1'b1)
        fragCount++;
    end
endmodule // tdc_ev_builder

/* testbench/tdc_hit_capture_tb.sv */
// self-checking bench for the hit capture block
`timescale 1ns/1ns
module tdc_hit_capture_tb;
  logic                                            ref_clk, rst_n, ce, trigger;
  logic                                            evReady, evValid, evLast, busy, stallEn;
  logic [tdc_pkg::NUM_CH-1:0][tdc_pkg::FINE_N-1:0] fineWords;
  logic [1:0]                                      instIdx;
  logic [tdc_pkg::TIME_W-1:0]                      winOffset, winWidth;
  logic [31:0]                                     evData, rng;
  logic [tdc_pkg::NUM_CH-1:0]                      lvl;
  logic [22:0]                                     expHits[$];
  int                                              tick = 0;
  int                                              fail_count, cmp_count;

  tdc_hit_capture dut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .fineWords(fineWords),
    .instIdx(instIdx), .winOffset(winOffset), .winWidth(winWidth), .trigger(trigger),
    .evReady(evReady), .evData(evData), .evValid(evValid), .evLast(evLast), .busy(busy));

  tdc_ev_builder eb (.ref_clk(ref_clk), .ce(ce), .evData(evData), .evValid(evValid),
    .evLast(evLast), .evReady(evReady), .stallEn(stallEn));

  ////////////////////////////////////////////////////////////////////////////////
  // random source and expected word head
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [15:0] hitHead(input logic [22:0] e);
    return {1'b1, tdc_pkg::TYPE_HIT, e[22], 2'b00, instIdx, e[21:16]};
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // one edge at sample position p, remembered as expected hit
  task automatic edgeOn(input int ch, input logic [2:0] p);
    fineWords[ch] = lvl[ch] ? 8'hff >> (8 - int'(p)) : 8'hff << p;
    expHits.push_back({lvl[ch], 6'(ch), tick[12:0], p});
    lvl[ch] = ~lvl[ch];
  endtask

  // hold every channel at its level, then let the queues drain
  task automatic settle();
    @(negedge ref_clk);
    foreach (lvl[i])
      fineWords[i] = {8{lvl[i]}};
    repeat (20) @(negedge ref_clk);
  endtask

  // one edge per 21 cycles keeps every group far below its rate limit
  task automatic randomHits(input int n);
    repeat (n)
    begin
      rng = xorshift(rng);
      edgeOn(int'(rng[5:0]), rng[10:8]);
      settle();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // trigger, refuse a retrigger while busy, collect and compare the fragment
  task automatic fragment(input logic [15:0] off, input logic [15:0] width);
    int          n0, k, g, m;
    logic [31:0] w;
    logic [15:0] ws;
    logic [22:0] pool[$];
    // window start in the bench time base, pool holds hits inside it
    ws = {tick[12:0], 3'h0} - off;
    foreach (expHits[i])
      if (16'(expHits[i][15:0] - ws) < width)
        pool.push_back(expHits[i]);
    winOffset = off;
    winWidth  = width;
    n0        = eb.fragCount;
    eb.words.delete();
    trigger = 1'b1;
    @(negedge ref_clk);
    trigger = 1'b0;
    @(negedge ref_clk);
    check("busy", 1, busy); // take flagged
    trigger = 1'b1;
    @(negedge ref_clk);
    trigger = 1'b0;
    for (k = 0; k < 4000 && eb.fragCount == n0; k++)
      @(negedge ref_clk);
    repeat (8) @(negedge ref_clk);
    check("fragments", n0 + 1, eb.fragCount); // one fragment per take
    check("busy end", 0, busy); // idle after end
    check("words", pool.size() + 1, eb.words.size()); // every in-window hit read out
    check("end word", {1'b1, tdc_pkg::TYPE_FILL, 27'h0}, eb.words.pop_back()); // tag
    g = 0;
    foreach (eb.words[i])
    begin
      w = eb.words[i];
      m = -1;
      foreach (pool[j])
        if (m < 0 && hitHead(pool[j]) === w[31:16] && 16'(pool[j][15:0] - ws) === w[15:0])
          m = j;
      check("hit match", 1, m >= 0); // fields and hit time
      if (m >= 0)
        pool.delete(m);
      check("group order", 1, int'(w[21:20]) >= g); // groups in order
      g = int'(w[21:20]);
      check("hit window", 1, w[15:0] <= off); // time from window start
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // clock source, bench time base and watchdog
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // coarse ticks since reset release, one per clock
  always @(posedge ref_clk)
    if (rst_n)
      tick <= tick + 1;

  initial
  begin
    #100000;
    fail_count++;
    test_done();
  end

  // main sequence
  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    trigger = 1'b0;
    instIdx = 2'h2;
    winOffset = 16'h0;
    winWidth = 16'h0;
    fineWords = '0;
    lvl = '0;
    stallEn = 1'b0;
    rng = 32'h7;
    fail_count = 0;
    cmp_count = 0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    check("reset valid", 0, evValid); // quiet in reset
    check("reset busy", 0, busy); // quiet in reset
    check("reset coarse", 0, dut.coarse); // time origin
    rst_n = 1'b1;
    fragment(16'h8000, 16'hffff);
    // fine bit corners on channel zero
    edgeOn(0, 3'h0);
    settle();
    edgeOn(0, 3'h7);
    settle();
    randomHits(10);
    fragment(16'h8000, 16'hffff);
    stallEn = 1'b1;
    for (int c = 32; c < 48; c++)
      edgeOn(c, 3'(c));
    settle();
    randomHits(10);
    fragment(16'h0400, 16'h0200);
    fragment(16'h8000, 16'hffff);
    fragment(16'h0000, 16'h0100);
    repeat (tdc_pkg::HOLD_CYCLES) @(negedge ref_clk);
    fragment(16'h8000, 16'hffff);
    test_done();
  end
endmodule // tdc_hit_capture_tb
